// ---- hdl/apdv_map.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef APDV_MAP_SVH
`define APDV_MAP_SVH
// Register byte offsets
`define APDV_OFF_CTRL 8'h00
`define APDV_OFF_LAST_UUI 8'h04
`define APDV_OFF_REMOTE_TS 8'h08
`define APDV_OFF_TOTAL_SLIP 8'h0C
`define APDV_OFF_DESIRED 8'h10
`define APDV_OFF_LAST_BUS_TS 8'h14
`define APDV_OFF_INIT_LEAD 8'h18
`define APDV_OFF_MIN_DELAY 8'h1C
`define APDV_OFF_MAX_DELAY 8'h20
`define APDV_OFF_INTERCHIP 8'h24
// Control register field positions
`define APDV_F_INTERVAL_LSB 0
`define APDV_F_OVR_FREEZE 8
`define APDV_F_UNR_FREEZE 9
`define APDV_F_TEST_BIT 10
`define APDV_F_SEQ_BITS_LSB 11
`define APDV_F_ALWAYS_RST 14
`define APDV_F_RST_NEXT 15
`define APDV_F_RST_SILENCE 16
`define APDV_F_RST_MARKER 17
`define APDV_F_MIN_SIL_LSB 18
`define APDV_F_INIT_LEAD 21
`define APDV_F_INIT_DONE 22
// Reset values and limits
`define APDV_CTRL_RST 32'h0000_0028
`define APDV_MAX_SEQ_BITS 3'h4
`define APDV_SIL_BASE 32'h0000_0010
`define APDV_UUI_W 5
`endif

// ---- hdl/apdv_pkg.sv ----
// Types for the AAL2 delay-variation slip control block
package apdv_pkg;
    // One received voice packet
    typedef struct packed {
        logic [4:0] uui;     // UUI field of the packet
        logic marker;        // RTP marker bit
        logic [7:0] frames;  // Frames carried by the packet
    } apdv_pkt_type;
    // Slip event towards the disassembly event writer
    typedef struct packed {
        logic overrun;       // Packet arrived too early
        logic underrun;      // Packet arrived too late
        logic slip_reset;    // Total slip was reset or initialised
        logic [31:0] err;    // Signed error against the target delta
    } apdv_event_type;
    // Processing states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXTEND = 2'b01,
        ST_APPLY = 2'b10
    } apdv_state_type;
endpackage

// ---- hdl/apdv_slip_ctrl.sv ----
// Delay-variation slip control for one received AAL2 voice channel
//
// Contract
// - Sequence step advances remote stamp interval frames.
// - Overrun freeze keeps slip, raises event only.
// - Underrun freeze keeps slip, raises event only.
// - Use programmed low UUI bits, zero to four.
// - Always-reset plays every packet but an init-with-lead one at desired delta.
// - Record local bus stamp per processed packet.
// - Reset-on-next zeroes slip on next packet.
// - Reset-after-silence zeroes slip after long gap.
// - Reset-on-marker zeroes slip on marked packet.
// - Clear one-shot reset bit once applied.
// - Silence threshold is sixteen shifted by code.
// - Init-with-lead loads shortest delay plus lead.
// - Without init lead, trust delta, slip normally.
// - First packet sets init flag to one.
// - Keep last UUI, compare as non-decreasing.
// - Extend UUI into 32-bit remote stamp.
// - Slip is signed; overrun positive, underrun negative.
// - Zero delta plays stamp zero at time zero.
// - Delta equals remote stamp minus local stamp.
`include "apdv_map.svh"

module apdv_slip_ctrl
    import apdv_pkg::*;
(
    input wire logic pclk,                 // Bus and core clock
    input wire logic presetn,              // Asynchronous reset, low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB access phase
    input wire logic pwrite,               // APB write
    input wire logic [7:0] paddr,          // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error on unmapped
    input wire logic [31:0] bus_ts,        // Local TDM bus time stamp
    input wire logic pkt_valid,            // Packet offered
    input wire apdv_pkt_type pkt_in,       // Packet fields
    output logic pkt_ready,                // Packet can be taken
    output logic play_valid,               // Playout answer pulse
    output logic [31:0] play_ts,           // Local stamp for first byte
    output logic event_valid,              // Event pulse
    output apdv_event_type event_out       // Event contents
);

    // Silence threshold from the 3-bit code
    function automatic logic [31:0] sil_limit(input logic [2:0] code);
        sil_limit = `APDV_SIL_BASE << code;
    endfunction

    // Signed compare of two modular stamps
    function automatic logic s_gt(input logic [31:0] a, input logic [31:0] b);
        s_gt = $signed(a) > $signed(b);
    endfunction

    // Register file
    logic [31:0] ctrl_reg, ctrl_next;      // Control fields
    logic [4:0] last_uui_reg;              // UUI of last packet
    logic [31:0] remote_ts_reg;            // Extended remote stamp
    logic [31:0] slip_reg, slip_next;      // Signed total slip
    logic [31:0] desired_reg;              // Desired remote-local delta
    logic [31:0] last_bus_reg;             // Bus stamp of last packet
    logic [31:0] lead_reg;                 // Initial lead
    logic [31:0] min_reg;                  // Shortest allowed delay
    logic [31:0] max_reg;                  // Longest allowed delay
    logic [31:0] ichip_reg;                // Reserved sync delta
    logic [7:0] last_frames_reg;           // Frames of last packet

    // Pipeline state
    apdv_state_type state_reg, state_next; // Sequencer
    apdv_pkt_type pkt_reg;                 // Latched packet
    logic [31:0] ts_ext_reg;               // Stamp computed for packet
    logic silent_reg;                      // Gap reached threshold
    logic play_valid_reg;                  // Output pulse
    logic [31:0] play_ts_reg;              // Output stamp
    logic event_valid_reg;                 // Event pulse
    apdv_event_type event_reg;             // Event contents

    // Control field views
    wire [7:0] seq_interval = ctrl_reg[`APDV_F_INTERVAL_LSB +: 8];
    wire overrun_freeze = ctrl_reg[`APDV_F_OVR_FREEZE];
    wire underrun_freeze = ctrl_reg[`APDV_F_UNR_FREEZE];
    wire [2:0] seq_bits_raw = ctrl_reg[`APDV_F_SEQ_BITS_LSB +: 3];
    wire always_reset = ctrl_reg[`APDV_F_ALWAYS_RST];
    wire reset_on_next = ctrl_reg[`APDV_F_RST_NEXT];
    wire reset_after_silence = ctrl_reg[`APDV_F_RST_SILENCE];
    wire reset_on_marker = ctrl_reg[`APDV_F_RST_MARKER];
    wire [2:0] min_silence = ctrl_reg[`APDV_F_MIN_SIL_LSB +: 3];
    wire init_with_lead = ctrl_reg[`APDV_F_INIT_LEAD];
    wire init_done_flag = ctrl_reg[`APDV_F_INIT_DONE];

    // APB decode; slave answers in the access cycle itself
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire hit_ctrl = paddr == `APDV_OFF_CTRL;
    wire hit_uui = paddr == `APDV_OFF_LAST_UUI;
    wire hit_rts = paddr == `APDV_OFF_REMOTE_TS;
    wire hit_slip = paddr == `APDV_OFF_TOTAL_SLIP;
    wire hit_des = paddr == `APDV_OFF_DESIRED;
    wire hit_bts = paddr == `APDV_OFF_LAST_BUS_TS;
    wire hit_lead = paddr == `APDV_OFF_INIT_LEAD;
    wire hit_min = paddr == `APDV_OFF_MIN_DELAY;
    wire hit_max = paddr == `APDV_OFF_MAX_DELAY;
    wire hit_ich = paddr == `APDV_OFF_INTERCHIP;
    wire hit_any = hit_ctrl || hit_uui || hit_rts || hit_slip || hit_des
                   || hit_bts || hit_lead || hit_min || hit_max || hit_ich;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !hit_any;

    // Read mux, unmapped reads as zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata = ctrl_reg;
        end else if (hit_uui) begin
            prdata = {27'h000_0000, last_uui_reg};
        end else if (hit_rts) begin
            prdata = remote_ts_reg;
        end else if (hit_slip) begin
            prdata = slip_reg;
        end else if (hit_des) begin
            prdata = desired_reg;
        end else if (hit_bts) begin
            prdata = last_bus_reg;
        end else if (hit_lead) begin
            prdata = lead_reg;
        end else if (hit_min) begin
            prdata = min_reg;
        end else if (hit_max) begin
            prdata = max_reg;
        end else if (hit_ich) begin
            prdata = ichip_reg;
        end
    end

    // Sequence bits limited to four
    wire [2:0] seq_bits = (seq_bits_raw > `APDV_MAX_SEQ_BITS) ?
                          `APDV_MAX_SEQ_BITS : seq_bits_raw;
    wire [4:0] uui_mask = 5'((6'h01 << seq_bits) - 6'h01);
    // UUI assumed constant or incrementing, so modular difference
    wire [4:0] uui_step = (pkt_reg.uui - last_uui_reg) & uui_mask;
    wire [31:0] step_frames = (seq_bits == 3'h0) ?
                              {24'h00_0000, last_frames_reg} :
                              32'(uui_step) * 32'(seq_interval);
    // First packet keeps the arbitrary starting stamp
    wire [31:0] ts_ext_calc = init_done_flag ?
                              remote_ts_reg + step_frames :
                              remote_ts_reg;
    logic [31:0] bus_ts_latched;           // Bus stamp at acceptance

    // Delta and error against the current target
    wire [31:0] delta = ts_ext_reg - bus_ts_latched;
    wire [31:0] target = desired_reg + slip_reg;
    wire [31:0] err = delta - target;
    wire is_ovr = s_gt(err, max_reg);
    wire is_unr = s_gt(min_reg, err);
    wire [31:0] ovr_excess = err - max_reg;
    wire [31:0] unr_excess = err - min_reg;

    // Priority of slip actions in the apply cycle
    wire apply = state_reg == ST_APPLY;
    wire do_init = !init_done_flag && init_with_lead;
    wire do_always = !do_init && always_reset;
    wire do_rso = !do_init && !do_always && reset_on_next;
    wire do_rsl = !do_init && !do_always && !do_rso
                  && reset_after_silence && silent_reg;
    wire do_rsm = !do_init && !do_always && !do_rso && !do_rsl
                  && reset_on_marker && pkt_reg.marker;
    wire do_reset = do_always || do_rso || do_rsl || do_rsm;
    wire do_slip = !do_init && !do_reset;
    wire do_ovr = do_slip && is_ovr;
    wire do_unr = do_slip && !is_ovr && is_unr;

    // Slip value after this packet
    always_comb begin
        slip_next = slip_reg;
        if (do_init) begin
            slip_next = min_reg + lead_reg;
        end else if (do_reset) begin
            slip_next = 32'h0000_0000;
        end else if (do_ovr && !overrun_freeze) begin
            slip_next = slip_reg + ovr_excess;
        end else if (do_unr && !underrun_freeze) begin
            slip_next = slip_reg + unr_excess;
        end
    end

    // Control update; software write wins over hardware clear,
    // but the init flag set by hardware is never lost
    always_comb begin
        ctrl_next = ctrl_reg;
        if (apb_wr && hit_ctrl) begin
            ctrl_next = pwdata;
        end else if (apply) begin
            if (do_rso) begin
                ctrl_next[`APDV_F_RST_NEXT] = 1'b0;
            end
            if (do_rsl) begin
                ctrl_next[`APDV_F_RST_SILENCE] = 1'b0;
            end
            if (do_rsm) begin
                ctrl_next[`APDV_F_RST_MARKER] = 1'b0;
            end
        end
        if (apply) begin
            ctrl_next[`APDV_F_INIT_DONE] = 1'b1;
        end
    end

    // Sequencer: accept, extend, apply
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = pkt_valid ? ST_EXTEND : ST_IDLE;
            ST_EXTEND: state_next = ST_APPLY;
            ST_APPLY: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end
    assign pkt_ready = state_reg == ST_IDLE;
    wire accept = pkt_valid && pkt_ready;
    // Gap since last packet, in local frames
    wire [31:0] gap_local = bus_ts_latched - last_bus_reg;
    wire silent_calc = init_done_flag &&
                       !s_gt(sil_limit(min_silence), gap_local);

    // Sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Packet latch on acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_reg <= '0;
            bus_ts_latched <= 32'h0000_0000;
        end else if (accept) begin
            pkt_reg <= pkt_in;
            bus_ts_latched <= bus_ts;
        end
    end

    // Remote stamp extension stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_ext_reg <= 32'h0000_0000;
            silent_reg <= 1'b0;
        end else if (state_reg == ST_EXTEND) begin
            ts_ext_reg <= ts_ext_calc;
            silent_reg <= silent_calc;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `APDV_CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Channel state written back by hardware or software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slip_reg <= 32'h0000_0000;
            remote_ts_reg <= 32'h0000_0000;
            last_uui_reg <= 5'h00;
            last_bus_reg <= 32'h0000_0000;
            last_frames_reg <= 8'h00;
        end else if (apply) begin
            slip_reg <= slip_next;
            remote_ts_reg <= ts_ext_reg;
            last_uui_reg <= pkt_reg.uui;
            last_bus_reg <= bus_ts_latched;
            last_frames_reg <= pkt_reg.frames;
        end else if (apb_wr) begin
            if (hit_slip) begin
                slip_reg <= pwdata;
            end
            if (hit_rts) begin
                remote_ts_reg <= pwdata;
            end
            if (hit_uui) begin
                last_uui_reg <= pwdata[4:0];
            end
        end
    end

    // Software-only setup registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desired_reg <= 32'h0000_0000;
            lead_reg <= 32'h0000_0000;
            min_reg <= 32'h0000_0000;
            max_reg <= 32'h0000_0000;
            ichip_reg <= 32'h0000_0000;
        end else if (apb_wr) begin
            if (hit_des) begin
                desired_reg <= pwdata;
            end
            if (hit_lead) begin
                lead_reg <= pwdata;
            end
            if (hit_min) begin
                min_reg <= pwdata;
            end
            if (hit_max) begin
                max_reg <= pwdata;
            end
            if (hit_ich) begin
                ichip_reg <= pwdata;
            end
        end
    end

    // Playout stamp and events, one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            play_valid_reg <= 1'b0;
            play_ts_reg <= 32'h0000_0000;
            event_valid_reg <= 1'b0;
            event_reg <= '0;
        end else begin
            play_valid_reg <= apply;
            event_valid_reg <= apply && (do_ovr || do_unr);
            if (apply) begin
                // Local stamp where first byte is played
                play_ts_reg <= ts_ext_reg - desired_reg - slip_next;
                event_reg.overrun <= do_ovr;
                event_reg.underrun <= do_unr;
                event_reg.slip_reset <= do_init || do_reset;
                event_reg.err <= err;
            end
        end
    end
    assign play_valid = play_valid_reg;
    assign play_ts = play_ts_reg;
    assign event_valid = event_valid_reg;
    assign event_out = event_reg;

    // Checks
    sequence seq_accept;
        pkt_valid && pkt_ready;
    endsequence
    sequence seq_walk;
        (state_reg == ST_EXTEND) ##1 (state_reg == ST_APPLY);
    endsequence

    AST_PIPE: assert property (@(posedge pclk) disable iff (!presetn)
        seq_accept |=> seq_walk ##1 play_valid)
        else $error("packet answer not three cycles after accept");
    AST_OVR_FREEZE: assert property (@(posedge pclk)
        disable iff (!presetn)
        (apply && do_ovr && overrun_freeze) |=> $stable(slip_reg)
        ##0 event_valid && event_out.overrun)
        else $error("frozen overrun changed slip or gave no event");
    AST_UNR_FREEZE: assert property (@(posedge pclk)
        disable iff (!presetn)
        (apply && do_unr && underrun_freeze) |=> $stable(slip_reg)
        ##0 event_valid && event_out.underrun)
        else $error("frozen underrun changed slip or gave no event");
    AST_ALWAYS: assert property (@(posedge pclk) disable iff (!presetn)
        (apply && init_done_flag && always_reset) |=>
        slip_reg == 32'h0000_0000 && !event_valid)
        else $error("always-reset left slip nonzero");
    AST_BUS_TS: assert property (@(posedge pclk) disable iff (!presetn)
        seq_accept ##3 1'b1 |-> last_bus_reg == $past(bus_ts, 3))
        else $error("recorded bus stamp wrong");
    AST_RSO: assert property (@(posedge pclk) disable iff (!presetn)
        (apply && do_rso && !(apb_wr && hit_ctrl)) |=>
        !reset_on_next && slip_reg == 32'h0000_0000)
        else $error("reset-on-next not applied and cleared");
    AST_INIT: assert property (@(posedge pclk) disable iff (!presetn)
        apply |=> init_done_flag)
        else $error("init flag not set after packet");
    AST_LEAD: assert property (@(posedge pclk) disable iff (!presetn)
        (apply && do_init) |=> slip_reg == $past(min_reg) + $past(lead_reg))
        else $error("initial slip not shortest delay plus lead");
    AST_OVR_SIGN: assert property (@(posedge pclk)
        disable iff (!presetn)
        (apply && do_ovr && !overrun_freeze) |=>
        slip_reg - $past(slip_reg) == $past(ovr_excess))
        else $error("overrun slip not added positively");
    AST_REMOTE: assert property (@(posedge pclk)
        disable iff (!presetn)
        (state_reg == ST_EXTEND && init_done_flag && seq_bits == 3'h1
         && !(apb_wr && hit_rts)) |=>
        ts_ext_reg == $past(remote_ts_reg) + 32'($past(uui_step))
        * 32'($past(seq_interval)))
        else $error("remote stamp step not interval per sequence");

endmodule

// ---- tb/apdv_sender.sv ----
// Remote AAL2 sender model that offers voice packets to the block
module apdv_sender
    import apdv_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic pkt_ready, // Block can take a packet
    output logic pkt_valid, // Packet offered
    output apdv_pkt_type pkt_in // Packet fields
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] uui_reg; // UUI of the last packet sent
    // Quiet lines at time zero
    initial begin
        pkt_valid = 1'h0;
        pkt_in = '0;
        uui_reg = 5'h00;
    end
    // Offer one packet, hold it until taken, then let the lines go
    task automatic send(input logic [4:0] step, input logic mk,
                        input logic [7:0] fr);
        uui_reg = uui_reg + step;
        pkt_valid <= 1'h1;
        pkt_in <= '{uui: uui_reg, marker: mk, frames: fr};
        // Ready is combinational, so look at it while it is settled
        do @(negedge pclk); while (pkt_ready !== 1'h1);
        @(posedge pclk);
        pkt_valid <= 1'h0;
        // Released lines show the inverse, never a stale copy
        pkt_in <= ~pkt_in;
    endtask
endmodule

// ---- tb/test_aal2_pdv_slip_control.sv ----
// Self-checking bench for the AAL2 delay-variation slip control block
`include "apdv_map.svh"
module test_aal2_pdv_slip_control
    import apdv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // Bus pins
    logic [7:0] paddr; // Byte address
    logic [31:0] pwdata, prdata, bus_ts, play_ts; // Data and stamps
    logic pkt_valid, pkt_ready, play_valid, event_valid; // Handshakes
    apdv_pkt_type pkt_in; // Offered packet
    apdv_event_type event_out; // Slip event
    int err_total = 0, checked = 0, cycles = 0; // Tallies
    // Expected state of the channel structure
    logic [31:0] m_ctrl, m_rem, m_slip, m_des, m_min, m_max, m_lead, m_bus;
    logic [31:0] e_play, rd, e_err; // Expected playout and error, read data
    logic [2:0] e_flg; // Expected overrun, underrun, slip reset flags
    logic [4:0] m_uui; // Last UUI
    logic [7:0] m_frm; // Frames of last packet
    logic e_ev, serr; // Expected event, last slave error

    apdv_slip_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_ts(bus_ts), .pkt_valid(pkt_valid),
        .pkt_in(pkt_in), .pkt_ready(pkt_ready), .play_valid(play_valid),
        .play_ts(play_ts), .event_valid(event_valid),
        .event_out(event_out));
    apdv_sender i_snd (.pclk(pclk), .pkt_ready(pkt_ready),
        .pkt_valid(pkt_valid), .pkt_in(pkt_in));

    // 125 MHz clock
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            end_sim();
        end
    end
    // Closing report
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, plus an idle cycle so no pin is set twice at once
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // Load the channel structure from the expected state
    task automatic cfg();
        apb(1'h1, `APDV_OFF_CTRL, m_ctrl);
        apb(1'h1, `APDV_OFF_REMOTE_TS, m_rem);
        apb(1'h1, `APDV_OFF_TOTAL_SLIP, m_slip);
        apb(1'h1, `APDV_OFF_DESIRED, m_des);
        apb(1'h1, `APDV_OFF_INIT_LEAD, m_lead);
        apb(1'h1, `APDV_OFF_MIN_DELAY, m_min);
        apb(1'h1, `APDV_OFF_MAX_DELAY, m_max);
        apb(1'h1, `APDV_OFF_INTERCHIP, 32'h0000_0000);
    endtask
    // What one packet should do to the structure
    function automatic void model(input logic [4:0] u, input logic mk,
                                  input logic [7:0] fr, input logic [31:0] ts);
        logic [2:0] nb;
        logic [31:0] d;
        nb = (m_ctrl[13:11] > 3'h4) ? 3'h4 : m_ctrl[13:11];
        d = 32'((u - m_uui) & 5'((6'h01 << nb) - 6'h01));
        e_ev = 1'h0;
        e_flg = 3'h1;
        // First packet keeps the remote stamp as loaded
        if (m_ctrl[22]) begin
            d = (nb == 3'h0) ? 32'(m_frm) : d * m_ctrl[7:0];
            m_rem = m_rem + d;
        end
        e_err = m_rem - ts - m_des - m_slip;
        // Without a lead the first packet takes the normal path
        if (!m_ctrl[22] && m_ctrl[21]) begin
            m_slip = m_min + m_lead;
        end else if (m_ctrl[14]) begin
            m_slip = '0;
        end else if (m_ctrl[15]) begin
            m_slip = '0;
            m_ctrl[15] = 1'h0;
        end else if (m_ctrl[16] && m_ctrl[22]
                     && ts - m_bus >= 32'h10 << m_ctrl[20:18]) begin
            m_slip = '0;
            m_ctrl[16] = 1'h0;
        end else if (m_ctrl[17] && mk) begin
            m_slip = '0;
            m_ctrl[17] = 1'h0;
        end else begin
            d = e_err;
            e_flg = 3'h0;
            if ($signed(d) > $signed(m_max)) begin
                e_ev = 1'h1;
                e_flg = 3'h4;
                if (!m_ctrl[8]) m_slip = m_slip + d - m_max;
            end else if ($signed(d) < $signed(m_min)) begin
                e_ev = 1'h1;
                e_flg = 3'h2;
                if (!m_ctrl[9]) m_slip = m_slip + d - m_min;
            end
        end
        m_ctrl[22] = 1'h1;
        e_play = m_rem - m_des - m_slip;
        m_uui = u;
        m_frm = fr;
        m_bus = ts;
    endfunction
    // Send a packet after a local gap, then check answer and structure
    task automatic run_pkt(input logic [4:0] s, input logic mk,
                           input logic [31:0] gap);
        logic [7:0] fr;
        int n;
        fr = 8'($urandom);
        bus_ts <= bus_ts + gap;
        i_snd.send(s, mk, fr);
        model(m_uui + s, mk, fr, bus_ts);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (play_valid !== 1'h1 && n < 8);
        chk({31'h0, play_valid}, 32'h0000_0001);
        chk(play_ts, e_play);
        chk({31'h0, event_valid}, {31'h0, e_ev});
        chk(event_out.err, e_err);
        chk({29'h0, event_out[34:32]}, {29'h0, e_flg});
        @(posedge pclk);
        rdc(`APDV_OFF_TOTAL_SLIP, m_slip);
        rdc(`APDV_OFF_REMOTE_TS, m_rem);
        rdc(`APDV_OFF_LAST_UUI, {27'h0, m_uui});
        rdc(`APDV_OFF_LAST_BUS_TS, m_bus);
        rdc(`APDV_OFF_CTRL, m_ctrl);
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        bus_ts = 32'hFFFF_F000; // Local stamp wraps early in the run
        void'($urandom(32'h0000_4b8b));
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdc(`APDV_OFF_CTRL, `APDV_CTRL_RST);
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk({31'h0, serr}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'h1, `APDV_OFF_LAST_BUS_TS, 32'hFFFF_FFFF);
        rdc(`APDV_OFF_LAST_BUS_TS, 32'h0000_0000);
        {m_slip, m_rem, m_des, m_bus, m_uui, m_frm} = '0;
        m_min = 32'hFFFF_FF9C;
        m_max = 32'h0000_0064;
        m_lead = 32'h0000_0010;
        m_ctrl = 32'h0000_2028; // Four sequence bits, interval 40
        cfg();
        run_pkt(5'h00, 1'h0, 32'h0000_0000);
        // Random controls; every twelfth pass restarts with a lead
        for (int i = 1; i < 48; i++) begin
            m_ctrl = $urandom & 32'h003F_BBFF;
            if (m_ctrl[7:0] == 8'h00) m_ctrl[7:0] = 8'hFF;
            m_ctrl[14] = ($urandom % 6 == 0);
            m_ctrl[22] = (i % 12 != 0);
            if (i % 12 == 0) m_ctrl[21] = 1'h1;
            if (i % 5 == 0) m_des = $urandom % 64;
            cfg();
            run_pkt(5'($urandom % 3), 1'($urandom),
                    ($urandom % 4 == 0) ? $urandom % 4096 : $urandom % 80);
        end
        end_sim();
    end
endmodule
